/* File: inc/abdac_pkg.sv */
// constants, types and register map of the audio bitstream dac register block
package abdac_pkg;

  // apb geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // control_word
  localparam logic [7:0] OFS_SD0 = 8'h04; // sample_data_ch0
  localparam logic [7:0] OFS_SD1 = 8'h08; // sample_data_ch1
  localparam logic [7:0] OFS_VOL0 = 8'h0c; // volume_ctrl_ch0
  localparam logic [7:0] OFS_VOL1 = 8'h10; // volume_ctrl_ch1
  localparam logic [7:0] OFS_IEN = 8'h14; // irq_enable_set
  localparam logic [7:0] OFS_IDIS = 8'h18; // irq_disable_clear
  localparam logic [7:0] OFS_IMASK = 8'h1c; // irq_mask_view
  localparam logic [7:0] OFS_STAT = 8'h20; // status_flags
  localparam logic [7:0] OFS_SCLR = 8'h24; // status_clear
  localparam logic [7:0] OFS_PARM = 8'h28; // parameter_info
  localparam logic [7:0] OFS_REV = 8'h2c; // module_revision

  // control_word field positions
  localparam int unsigned CTL_EN_BIT = 0;
  localparam int unsigned CTL_SWAP_BIT = 1;
  localparam int unsigned CTL_ALTUPR_BIT = 3;
  localparam int unsigned CTL_CMOC_BIT = 4;
  localparam int unsigned CTL_MONO_BIT = 5;
  localparam int unsigned CTL_SOFT_RESET_BIT_BIT = 7;
  localparam int unsigned CTL_FMT_LSB = 16;
  localparam int unsigned CTL_FS_LSB = 24;

  // volume fields
  localparam int unsigned VOL_MUTE_BIT = 31;
  localparam int unsigned VOL_W = 15;

  // status / mask bit positions
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_TX_READY_FLAG_BIT = 1;
  localparam int unsigned ST_UR_BIT = 2;

  // revision field
  localparam int unsigned REV_W = 12;
  localparam logic [11:0] REV_VALUE = 12'h005; // arbitrary value

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RST_MASK = 2'h0;

  // cross-domain transfer time, rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned XFER_TIME_NS = 160;
  localparam int unsigned XFER_CYC =
    (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // data word formats
  localparam logic [2:0] FMT_32 = 3'h0;
  localparam logic [2:0] FMT_24 = 3'h1;
  localparam logic [2:0] FMT_20 = 3'h2;
  localparam logic [2:0] FMT_18 = 3'h3;
  localparam logic [2:0] FMT_16 = 3'h4;
  localparam logic [2:0] FMT_16C = 3'h5;
  localparam logic [2:0] FMT_8 = 3'h6;
  localparam logic [2:0] FMT_8C = 3'h7;

  // configuration toward the conversion path
  typedef struct packed {
    logic [3:0] fs;
    logic [2:0] fmt;
    logic mono;
    logic cmoc;
    logic altupr;
    logic swap;
    logic en;
  } abdac_cfg_s;

  // one channel volume setting
  typedef struct packed {
    logic mute;
    logic [14:0] vol;
  } abdac_vol_s;

  // one stereo frame
  typedef struct packed {
    logic [31:0] ch1;
    logic [31:0] ch0;
  } abdac_frame_s;

  // transfer tracker states
  typedef enum logic [1:0] {
    XF_IDLE = 2'b01,
    XF_BUSY = 2'b10
  } abdac_xf_e;

endpackage

/* File: rtl/abdac_regs.sv */
// apb register block and frame hand-off of the audio bitstream dac
//
// How it works
// - channel 0 mute bit 31 silences it
// - channel 0 scaled by 15-bit volume
// - channel 1 mute bit 31 silences it
// - channel 1 scaled by 15-bit volume
// - enable-set ones set mask bits
// - disable-clear ones clear mask bits
// - zero bits written change nothing
// - mask bit one enables that interrupt
// - underrun flag sticky until reset or clear
// - tx ready shows room for sample
// - busy blocks control and sample writes
// - status clear drops flag and request
// - parameter register reads all zeros
// - revision register returns 12-bit version
// - bus side and conversion side split
// - software reset bit resets whole block
`timescale 1ns/10ps
`default_nettype none

module abdac_regs (
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // sync reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction, 1 = write
  input wire logic [abdac_pkg::ADDR_W-1:0] paddr_i, // apb byte address
  input wire logic [abdac_pkg::DATA_W-1:0] pwdata_i, // apb write data
  output logic [abdac_pkg::DATA_W-1:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error, unmapped address
  output logic irq_o, // interrupt request level
  input wire logic sample_req_i, // conversion path wants a frame
  output abdac_pkg::abdac_cfg_s cfg_o, // configuration to datapath
  output abdac_pkg::abdac_frame_s frame_o, // scaled frame
  output logic frame_valid_o // one-cycle frame strobe
);
  import abdac_pkg::*;

  // sign-extend a right-justified sample of the given format
  function automatic logic [31:0] align(input logic [31:0] raw,
                                        input logic [2:0] fmt,
                                        input logic upper);
    logic [31:0] r;
    r = raw;
    case (fmt)
      FMT_24: r = {{8{raw[23]}}, raw[23:0]};
      FMT_20: r = {{12{raw[19]}}, raw[19:0]};
      FMT_18: r = {{14{raw[17]}}, raw[17:0]};
      FMT_16: r = {{16{raw[15]}}, raw[15:0]};
      FMT_16C: begin
        if (upper) begin
          r = {{16{raw[31]}}, raw[31:16]};
        end else begin
          r = {{16{raw[15]}}, raw[15:0]};
        end
      end
      FMT_8: r = {{24{raw[7]}}, raw[7:0]};
      FMT_8C: begin
        if (upper) begin
          r = {{24{raw[15]}}, raw[15:8]};
        end else begin
          r = {{24{raw[7]}}, raw[7:0]};
        end
      end
      default: r = raw;
    endcase
    return r;
  endfunction

  // apply mute and volume; full scale volume is just under unity
  function automatic logic [31:0] scale(input logic [31:0] s,
                                        input abdac_vol_s v);
    logic signed [47:0] p;
    p = 48'($signed(s)) * 48'($signed({1'b0, v.vol}));
    if (v.mute) begin
      return RST_ZERO;
    end
    return p[46:15];
  endfunction

  // soft reset folds into the block reset for one cycle
  logic soft_rst_q; // software reset pulse
  logic blk_rst; // hardware or software reset
  assign blk_rst = rst_i | soft_rst_q;

  // apb phase decode
  logic setup_rd; // read setup cycle
  logic acc; // access completes this edge
  logic wr; // write takes effect this edge
  logic mapped; // address hits a register
  logic busy; // cross-domain transfer running

  // zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i & mapped;
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFS_REV);
  assign pslverr_o = acc & ~mapped;

  // per-register write strobes
  logic wr_ctrl, wr_sd0, wr_sd1; // blocked while busy
  logic wr_ien, wr_idis, wr_sclr; // set/clear strobes
  assign wr_ctrl = wr && paddr_i == OFS_CTRL && !busy;
  assign wr_sd0 = wr && paddr_i == OFS_SD0 && !busy;
  assign wr_sd1 = wr && paddr_i == OFS_SD1 && !busy;
  assign wr_ien = wr && paddr_i == OFS_IEN;
  assign wr_idis = wr && paddr_i == OFS_IDIS;
  assign wr_sclr = wr && paddr_i == OFS_SCLR;

  // software reset is taken even while busy so a hung transfer can be
  // recovered; its own flop only answers to the pin reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr && paddr_i == OFS_CTRL
                    && pwdata_i[CTL_SOFT_RESET_BIT_BIT];
    end
  end

  // control word
  abdac_cfg_s cfg_q; // live configuration
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      cfg_q <= '0;
    end else if (wr_ctrl) begin
      cfg_q.en <= pwdata_i[CTL_EN_BIT];
      cfg_q.swap <= pwdata_i[CTL_SWAP_BIT];
      cfg_q.altupr <= pwdata_i[CTL_ALTUPR_BIT];
      cfg_q.cmoc <= pwdata_i[CTL_CMOC_BIT];
      cfg_q.mono <= pwdata_i[CTL_MONO_BIT];
      cfg_q.fmt <= pwdata_i[CTL_FMT_LSB +: 3];
      cfg_q.fs <= pwdata_i[CTL_FS_LSB +: 4];
    end
  end
  assign cfg_o = cfg_q;

  // sample holding registers; data is stored as written
  logic [31:0] sd0_q, sd1_q; // raw sample words
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      sd0_q <= RST_ZERO;
      sd1_q <= RST_ZERO;
    end else begin
      if (wr_sd0) begin
        sd0_q <= pwdata_i;
      end
      if (wr_sd1) begin
        sd1_q <= pwdata_i;
      end
    end
  end

  // volume registers for both channels
  abdac_vol_s vol_q [2]; // mute and gain per channel
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_vol
      always_ff @(posedge clk_i) begin
        if (blk_rst) begin
          vol_q[gc] <= '0;
        end else if (wr && paddr_i == (gc == 0 ? OFS_VOL0 : OFS_VOL1)) begin
          vol_q[gc].mute <= pwdata_i[VOL_MUTE_BIT];
          vol_q[gc].vol <= pwdata_i[VOL_W-1:0];
        end
      end
    end
  endgenerate

  // transfer tracker: each accepted control or sample write is carried to
  // the conversion side, which holds busy for a fixed number of cycles
  abdac_xf_e xf_q; // tracker state
  logic [2:0] xf_cnt_q; // cycles left in transfer
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      xf_q <= XF_IDLE;
      xf_cnt_q <= 3'h0;
    end else begin
      case (xf_q)
        XF_IDLE: begin
          if (wr_ctrl || wr_sd0 || wr_sd1) begin
            xf_q <= XF_BUSY;
            xf_cnt_q <= 3'(XFER_CYC - 1);
          end
        end
        XF_BUSY: begin
          if (xf_cnt_q == 3'h0) begin
            xf_q <= XF_IDLE;
          end else begin
            xf_cnt_q <= xf_cnt_q - 3'h1;
          end
        end
        default: begin
          xf_q <= XF_IDLE;
        end
      endcase
    end
  end
  assign busy = (xf_q == XF_BUSY);

  // frame pending: a write to channel 0 commits the frame, so software
  // writes channel 1 first
  logic pend_q; // frame waiting for conversion side
  logic take; // conversion side takes the frame
  logic starve; // request finds nothing
  assign take = sample_req_i & cfg_q.en & pend_q & ~busy;
  assign starve = sample_req_i & cfg_q.en & ~pend_q;
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      pend_q <= 1'b0;
    end else if (wr_sd0) begin
      pend_q <= 1'b1; // new frame outranks the take
    end else if (take) begin
      pend_q <= 1'b0;
    end
  end

  // build and deliver the frame on the bus clock; the conversion path
  // sees it through sample_req_i and frame_valid_o
  logic [31:0] al0, al1; // aligned samples
  logic [31:0] sc0, sc1; // scaled samples
  always_comb begin
    al0 = align(sd0_q, cfg_q.fmt, 1'b0);
    if (cfg_q.fmt == FMT_16C || cfg_q.fmt == FMT_8C) begin
      al1 = align(sd0_q, cfg_q.fmt, 1'b1);
    end else begin
      al1 = align(sd1_q, cfg_q.fmt, 1'b0);
    end
    if (cfg_q.mono) begin
      al1 = al0; // channel 0 on both outputs
    end
    sc0 = scale(al0, vol_q[0]);
    sc1 = scale(al1, vol_q[1]);
  end

  // frame register toward the conversion side
  abdac_frame_s frame_q; // delivered frame
  logic fval_q; // delivery strobe
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      frame_q <= '0;
      fval_q <= 1'b0;
    end else begin
      fval_q <= take;
      if (take) begin
        if (cfg_q.swap) begin
          frame_q.ch0 <= sc1;
          frame_q.ch1 <= sc0;
        end else begin
          frame_q.ch0 <= sc0;
          frame_q.ch1 <= sc1;
        end
      end
    end
  end
  assign frame_o = frame_q;
  assign frame_valid_o = fval_q;

  // ready level: room for a new frame and no transfer in flight
  logic tx_ready_flag; // live ready level
  assign tx_ready_flag = ~pend_q & ~busy;

  // sticky flags; a new event wins over a clear in the same cycle
  logic ur_q; // underrun flag
  logic rdy_evt_q; // ready interrupt latch
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      ur_q <= 1'b0;
      rdy_evt_q <= 1'b0;
    end else begin
      if (starve) begin
        ur_q <= 1'b1;
      end else if (wr_sclr && pwdata_i[ST_UR_BIT]) begin
        ur_q <= 1'b0;
      end
      if (take) begin
        rdy_evt_q <= 1'b1;
      end else if (wr_sclr && pwdata_i[ST_TX_READY_FLAG_BIT]) begin
        rdy_evt_q <= 1'b0;
      end
    end
  end

  // interrupt mask, bit 1 = underrun, bit 0 = ready; set wins over clear
  logic [1:0] mask_q; // {underrun, ready}
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      mask_q <= RST_MASK;
    end else begin
      if (wr_ien && pwdata_i[ST_UR_BIT]) begin
        mask_q[1] <= 1'b1;
      end else if (wr_idis && pwdata_i[ST_UR_BIT]) begin
        mask_q[1] <= 1'b0;
      end
      if (wr_ien && pwdata_i[ST_TX_READY_FLAG_BIT]) begin
        mask_q[0] <= 1'b1;
      end else if (wr_idis && pwdata_i[ST_TX_READY_FLAG_BIT]) begin
        mask_q[0] <= 1'b0;
      end
    end
  end

  // interrupt request level
  assign irq_o = (ur_q & mask_q[1]) | (rdy_evt_q & mask_q[0]);

  // read mux; write-only and reserved registers return zero
  logic [31:0] rd_d; // value for the current address
  always_comb begin
    rd_d = RST_ZERO;
    case (paddr_i)
      OFS_CTRL: begin
        rd_d[CTL_EN_BIT] = cfg_q.en;
        rd_d[CTL_SWAP_BIT] = cfg_q.swap;
        rd_d[CTL_ALTUPR_BIT] = cfg_q.altupr;
        rd_d[CTL_CMOC_BIT] = cfg_q.cmoc;
        rd_d[CTL_MONO_BIT] = cfg_q.mono;
        rd_d[CTL_FMT_LSB +: 3] = cfg_q.fmt;
        rd_d[CTL_FS_LSB +: 4] = cfg_q.fs;
      end
      OFS_SD0: rd_d = sd0_q;
      OFS_SD1: rd_d = sd1_q;
      OFS_VOL0: begin
        rd_d[VOL_MUTE_BIT] = vol_q[0].mute;
        rd_d[VOL_W-1:0] = vol_q[0].vol;
      end
      OFS_VOL1: begin
        rd_d[VOL_MUTE_BIT] = vol_q[1].mute;
        rd_d[VOL_W-1:0] = vol_q[1].vol;
      end
      OFS_IMASK: begin
        rd_d[ST_UR_BIT] = mask_q[1];
        rd_d[ST_TX_READY_FLAG_BIT] = mask_q[0];
      end
      OFS_STAT: begin
        rd_d[ST_UR_BIT] = ur_q;
        rd_d[ST_TX_READY_FLAG_BIT] = tx_ready_flag;
        rd_d[ST_BUSY_BIT] = busy;
      end
      OFS_PARM: rd_d = RST_ZERO;
      OFS_REV: rd_d[REV_W-1:0] = REV_VALUE;
      default: rd_d = RST_ZERO;
    endcase
  end

  // read data is captured in the setup cycle and held through access
  logic [31:0] prdata_q; // registered read data
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      prdata_q <= RST_ZERO;
    end else if (setup_rd) begin
      prdata_q <= rd_d;
    end
  end
  assign prdata_o = prdata_q;

endmodule

`default_nettype wire

/* File: verif/abdac_conv_model.sv */
// conversion side stand-in: asks for frames at a set spacing
`timescale 1ns/10ps
`default_nettype none
module abdac_conv_model (
  input wire logic clk_i, // bus clock, shared with the block
  input wire logic rst_i, // sync reset
  input wire logic run_i, // keep asking while high
  input wire logic [7:0] gap_i, // cycles between requests, two or more
  output logic sample_req_o // one-cycle frame request
);
  logic [7:0] cnt_q; // cycles since last request
  // a request is a single-cycle pulse; stopping drops the count
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= 8'h00;
      sample_req_o <= 1'b0;
    end else begin
      sample_req_o <= (cnt_q == gap_i - 8'h01);
      cnt_q <= (cnt_q == gap_i - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verif/abdac_regs_chk.sv */
// assertion checker for the audio dac register block
`timescale 1ns/10ps
`default_nettype none
module abdac_regs_chk (
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // sync reset
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access
  input wire logic pwrite_i, // apb direction
  input wire logic [abdac_pkg::ADDR_W-1:0] paddr_i, // apb address
  input wire logic [abdac_pkg::DATA_W-1:0] pwdata_i, // apb write data
  input wire logic [abdac_pkg::DATA_W-1:0] prdata_o, // apb read data
  input wire logic pready_o, // apb ready
  input wire logic pslverr_o, // apb error
  input wire logic irq_o, // interrupt level
  input wire logic sample_req_i, // frame request
  input wire abdac_pkg::abdac_cfg_s cfg_o, // configuration
  input wire abdac_pkg::abdac_frame_s frame_o, // scaled frame
  input wire logic frame_valid_o // frame strobe
);
  import abdac_pkg::*;
  logic wr_acc; // write in its access cycle
  logic [1:0] mask_q; // shadow of mask bits 2:1
  logic [1:0] mute_q; // shadow of both mute bits
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wr_acc = psel_i && penable_i && pwrite_i;
  // shadows follow writes; a soft reset empties them like a hard one
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr_acc && paddr_i == OFS_CTRL && pwdata_i[7])) begin
      mask_q <= 2'h0;
      mute_q <= 2'h0;
    end else if (wr_acc && paddr_i == OFS_IEN) begin
      mask_q <= mask_q | pwdata_i[2:1];
    end else if (wr_acc && paddr_i == OFS_IDIS) begin
      mask_q <= mask_q & ~pwdata_i[2:1];
    end else if (wr_acc && paddr_i == OFS_VOL0) begin
      mute_q[0] <= pwdata_i[31];
    end else if (wr_acc && paddr_i == OFS_VOL1) begin
      mute_q[1] <= pwdata_i[31];
    end
  end
  // read setup cycle at one address
  sequence rd_setup(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence
  // write access cycle at one address
  sequence wr_access(logic [7:0] a);
    wr_acc && paddr_i == a;
  endsequence
  parm_zero_a: assert property (rd_setup(OFS_PARM) |=> prdata_o == 0)
    else $error("parameter read not zero");
  rev_value_a: assert property (rd_setup(OFS_REV) |=>
    prdata_o == {20'h0_0000, REV_VALUE})
    else $error("revision read wrong");
  wo_read_a: assert property ((rd_setup(OFS_IEN) or rd_setup(OFS_IDIS)
    or rd_setup(OFS_SCLR)) |=> prdata_o == 0)
    else $error("write-only register read not zero");
  mask_read_a: assert property (rd_setup(OFS_IMASK) |=>
    prdata_o == {29'h0000_0000, mask_q, 1'b0})
    else $error("mask read wrong");
  irq_masked_a: assert property (mask_q == 2'h0 |-> !irq_o)
    else $error("interrupt with all sources masked");
  irq_clear_a: assert property (wr_access(OFS_SCLR) ##0
    (pwdata_i[2:1] == 2'h3 && !sample_req_i) |=> !irq_o)
    else $error("interrupt stays after full clear");
  strobe_cause_a: assert property (frame_valid_o |->
    $past(sample_req_i && cfg_o.en))
    else $error("frame without enabled request");
  mute_zero_a: assert property (frame_valid_o && !cfg_o.mono &&
    !cfg_o.swap |-> (!$past(mute_q[0]) || frame_o.ch0 == 0) &&
    (!$past(mute_q[1]) || frame_o.ch1 == 0))
    else $error("muted channel not silent");
endmodule
bind abdac_regs abdac_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
  .sample_req_i(sample_req_i), .cfg_o(cfg_o), .frame_o(frame_o),
  .frame_valid_o(frame_valid_o));
`default_nettype wire

/* File: verif/audio_dac_volume_irq_regs_tb.sv */
// self-checking bench for the audio dac register block
`timescale 1ns/10ps
`default_nettype none
module audio_dac_volume_irq_regs_tb;
  import abdac_pkg::*;
  localparam logic [7:0] WO_ADDR [3] = '{OFS_IEN, OFS_IDIS, OFS_SCLR};
  logic clk_i = 1'b0; // bus clock
  logic rst_i, psel, pen, pwr, pready, perr, irq, req, fvalid, run, err_s;
  logic [7:0] paddr, gap; // address, request spacing
  logic [31:0] pwdata, prdata; // bus data
  abdac_cfg_s cfg; // configuration out
  abdac_frame_s frame; // frame out
  logic [31:0] rd_q[$]; // expected read data
  abdac_frame_s fr_q[$]; // expected frames
  int num_errors = 0;
  int total_checks = 0;
  always #20 clk_i = ~clk_i;
  abdac_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .irq_o(irq),
    .sample_req_i(req), .cfg_o(cfg), .frame_o(frame),
    .frame_valid_o(fvalid));
  abdac_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .gap_i(gap), .sample_req_o(req));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(1'b0, 1'b1, "pready timeout");
      complete_run();
    end
    err_s = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // irq sampled mid-cycle, once the edge's updates have landed
  task automatic chk_irq(input logic exp);
    @(negedge clk_i);
    check(irq, exp, "irq");
  endtask
  // kind 0: expected frames all seen; kind 1: irq high
  task automatic wait_until(input int kind);
    int n;
    n = 0;
    while ((kind == 0 ? fr_q.size() != 0 : irq !== 1'b1) && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) begin
      check(1'b0, 1'b1, "wait timeout");
      complete_run();
    end
  endtask
  // 32-bit sample times 15-bit volume, top bits kept; mute gives zero
  function automatic logic [31:0] scale(input logic [31:0] s,
                                        input logic [31:0] v);
    logic signed [47:0] p;
    p = 48'($signed(s)) * 48'($signed({1'b0, v[14:0]}));
    return v[31] ? 32'h0000_0000 : p[46:15];
  endfunction
  // watcher: each read result and each frame against the oldest note
  always @(posedge clk_i) begin
    if (psel && pen && !pwr && pready === 1'b1 && rd_q.size() > 0) begin
      check(prdata, rd_q.pop_front(), "read");
    end
    if (fvalid === 1'b1) begin
      if (fr_q.size() == 0) begin
        check(1'b0, 1'b1, "unexpected frame");
      end else begin
        check(frame.ch0, fr_q[0].ch0, "frame ch0");
        check(frame.ch1, fr_q[0].ch1, "frame ch1");
        void'(fr_q.pop_front());
      end
    end
  end
  initial begin
    logic [31:0] s0, s1, v0, v1;
    abdac_frame_s ef;
    {rst_i, psel, pen, pwr, run, paddr, gap, pwdata} = {5'h10, 48'h0};
    err_s = 1'b0;
    rst_i = 1'b1;
    run = 1'b0;
    void'($urandom(32'hed92a59f));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_VOL0, 32'h0000_0000);
    rd(OFS_VOL1, 32'h0000_0000);
    rd(OFS_STAT, 32'h0000_0002);
    wr(OFS_PARM, $urandom());
    rd(OFS_PARM, 32'h0000_0000);
    wr(OFS_REV, $urandom());
    rd(OFS_REV, {20'h0_0000, REV_VALUE});
    for (int i = 0; i < 3; i++) rd(WO_ADDR[i], 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    check(err_s, 1'b1, "unmapped error");
    $display("test map done");
    wr(OFS_IEN, 32'h0000_0006);
    rd(OFS_IMASK, 32'h0000_0006);
    wr(OFS_IDIS, 32'h0000_0002);
    rd(OFS_IMASK, 32'h0000_0004);
    for (int i = 0; i < 3; i++) wr(WO_ADDR[i], 32'hffff_fff9);
    rd(OFS_IMASK, 32'h0000_0004);
    chk_irq(1'b0);
    v0 = $urandom();
    wr(OFS_VOL0, v0);
    rd(OFS_VOL0, v0 & 32'h8000_7fff);
    wr(OFS_CTRL, 32'h0000_0080);
    idle(2);
    rd(OFS_VOL0, 32'h0000_0000);
    rd(OFS_IMASK, 32'h0000_0000);
    $display("test mask and soft reset done");
    wr(OFS_CTRL, 32'h0000_0001);
    idle(6);
    gap <= 8'h28;
    for (int i = 0; i < 4; i++) begin
      s0 = $urandom();
      s1 = $urandom();
      v0 = {i[0], 16'h0000, 15'($urandom())};
      v1 = {i[1], 16'h0000, 15'($urandom())};
      wr(OFS_CTRL, {30'h0, i[1], 1'b1});
      wr(OFS_VOL0, v0);
      wr(OFS_VOL1, v1);
      rd(OFS_VOL1, v1);
      check(32'(cfg), {30'h0, i[1], 1'b1}, "cfg");
      wr(OFS_SD1, s1);
      wr(OFS_SD1, ~s1);
      idle(6);
      rd(OFS_SD1, s1);
      wr(OFS_SD0, s0);
      idle(6);
      rd(OFS_STAT, 32'h0000_0000);
      // later passes swap the outputs, so each channel lands on the other
      if (i[1]) begin
        ef = {scale(s0, v0), scale(s1, v1)};
      end else begin
        ef = {scale(s1, v1), scale(s0, v0)};
      end
      fr_q.push_back(ef);
      run <= 1'b1;
      wait_until(0);
      run <= 1'b0;
      rd(OFS_STAT, 32'h0000_0002);
    end
    $display("test frames done");
    chk_irq(1'b0);
    wr(OFS_IEN, 32'h0000_0002);
    chk_irq(1'b1);
    wr(OFS_SCLR, 32'h0000_0002);
    chk_irq(1'b0);
    wr(OFS_IEN, 32'h0000_0004);
    run <= 1'b1;
    wait_until(1);
    run <= 1'b0;
    idle(50);
    rd(OFS_STAT, 32'h0000_0006);
    wr(OFS_IDIS, 32'h0000_0004);
    chk_irq(1'b0);
    wr(OFS_IEN, 32'h0000_0004);
    chk_irq(1'b1);
    wr(OFS_SCLR, 32'h0000_0006);
    chk_irq(1'b0);
    rd(OFS_STAT, 32'h0000_0002);
    $display("test interrupts done");
    complete_run();
  end
endmodule
`default_nettype wire
